// ### include/lmac_params.svh
/*
 * Constants of the LED matrix auxiliary control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes the register front end supplies the page number with every access.
 */
// Function
// - detect trigger rising edge starts open/short capture
// - results valid after the current scan cycle ends plus one full scan cycle
// - switched-off LEDs keep their stored open/short bits
// - one capture per trigger; clear then set
// - mask selects open, short, breath-done interrupt events
// - unmasked event pulls interrupt low, sets status
// - status read releases the interrupt pin
// - auto-clear releases interrupt after 8 ms low
// - interrupt release clears every status bit
// - sync field 01 drives scan clock out
// - sync field 10 follows scan clock in
// - sync field 00/11 floats pin, resets 00
// - anti-ghost pulls only on switched-off lines
// - bus reset pin high holds interface reset
// - registers keep contents through any shutdown
// - soft shutdown bit 0 blanks all sources
// - shutdown pin low disables analog, registers live
// - test gate bit guards three test registers
// - nonzero scan hold freezes the scan; 1-12 keep one row on, 13-15 none
// - 3-bit pull selectors, 000 means none
// - 128 us row slot, then 8 us gap
`ifndef LMAC_PARAMS_SVH
`define LMAC_PARAMS_SVH
`define LMAC_PAGE_LED 2'h0
`define LMAC_PAGE_FUNC 2'h3
`define LMAC_OFS_ONOFF_LAST 8'h17
`define LMAC_OFS_OPEN_FIRST 8'h18
`define LMAC_OFS_OPEN_LAST 8'h2f
`define LMAC_OFS_SHORT_FIRST 8'h30
`define LMAC_OFS_SHORT_LAST 8'h47
`define LMAC_OFS_CFG 8'h00
`define LMAC_OFS_GCL 8'h01
`define LMAC_OFS_PULLUP 8'h0f
`define LMAC_OFS_PULLDN 8'h10
`define LMAC_OFS_TEST_GATE 8'he0
`define LMAC_OFS_SCAN_HOLD 8'he1
`define LMAC_OFS_TEST_D2 8'he2
`define LMAC_OFS_TEST_D3 8'he3
`define LMAC_OFS_IRQ_MASK 8'hf0
`define LMAC_OFS_IRQ_STAT 8'hf1
`define LMAC_CFG_SSD_BIT 0
`define LMAC_CFG_BREATH_BIT 1
`define LMAC_CFG_DET_BIT 2
`define LMAC_CFG_SYNC_LSB 6
`define LMAC_MASK_IAC_BIT 5
`define LMAC_RST_BYTE 8'h00
`define LMAC_CLK_PS 4000
`define LMAC_ROW_SLOT_US 128
`define LMAC_NOL_US 8
`define LMAC_AUTOCLR_MS 8
`endif

// ### include/lmac_pkg.sv
/*
 * Types of the LED matrix auxiliary control block.
 * Assumes lmac_params.svh supplies every numeric constant.
 */
package lmac_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lmac_reg_req_t;
    typedef enum logic [1:0] {SYNC_OFF0, SYNC_MASTER, SYNC_SLAVE, SYNC_OFF3} lmac_sync_mode_t;
    typedef enum {SCAN_SLOT, SCAN_GAP} lmac_scan_state_t;
    typedef enum {DET_IDLE, DET_ALIGN, DET_CAPTURE} lmac_det_state_t;
endpackage : lmac_pkg

// ### logic/lmac_top.sv
/*
 * LED matrix auxiliary control: open/short capture, interrupt pin, scan
 * timing with chip-to-chip sync, anti-ghost pull enables, shutdown and the
 * protected test registers.
 * Assumes an I2C front end on i_ref_clk presents one-cycle register strobes
 * and the page number; open/short comparators and pins are asynchronous.
 */
`timescale 1ns/1ps
`include "lmac_params.svh"
module lmac_top #(
    parameter int SLOT_CYC = (`LMAC_ROW_SLOT_US * 1000000) / `LMAC_CLK_PS,
    parameter int GAP_CYC = (`LMAC_NOL_US * 1000000) / `LMAC_CLK_PS,
    parameter int AUTOCLR_CYC = (`LMAC_AUTOCLR_MS * 1000000) / (`LMAC_CLK_PS / 1000)
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire lmac_pkg::lmac_reg_req_t i_reg_req,
    output logic [7:0] o_reg_rdata,
    input wire logic i_bus_iface_reset_pin,
    input wire logic i_hw_shutdown_n_pin,
    input wire logic i_sync_in,
    output logic o_sync_out,
    output logic o_sync_oe,
    output logic o_irq_n_pin_out,
    output logic o_irq_n_pin_oe,
    input wire logic [15:0] i_col_open,
    input wire logic [15:0] i_col_short,
    input wire logic [2:0] i_breath_done,
    output logic [11:0] o_row_sink_line,
    output logic [15:0] o_column_source_line,
    output logic [11:0] o_row_pullup_en,
    output logic [15:0] o_column_pulldown_en,
    output logic [2:0] o_row_pullup_sel,
    output logic [2:0] o_column_pulldown_sel,
    output logic [7:0] o_global_current_level,
    output logic o_analog_en,
    output logic o_breath_en,
    output logic o_detect_busy
);
    localparam int ROWS = 12;
    localparam int PINS = 35;

    // ==========================================================
    // pin synchronisers
    logic [PINS-1:0] pin_s1_q;
    logic [PINS-1:0] pin_s2_q;
    logic sync_prev_q;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            sync_prev_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= {i_bus_iface_reset_pin, i_hw_shutdown_n_pin, i_sync_in, i_col_open, i_col_short};
            pin_s2_q <= pin_s1_q;
            sync_prev_q <= pin_s2_q[32];
        end
    end
    wire logic bus_rst = pin_s2_q[34];
    wire logic hw_on = pin_s2_q[33];
    wire logic sync_rise = pin_s2_q[32] & ~sync_prev_q;
    wire logic [15:0] col_open = pin_s2_q[31:16];
    wire logic [15:0] col_short = pin_s2_q[15:0];

    // ==========================================================
    // register access decode
    wire logic acc_ok = ~bus_rst;
    wire logic wr_ok = i_reg_req.wr & acc_ok;
    wire logic rd_ok = i_reg_req.rd & acc_ok;
    wire logic on_func = i_reg_req.page == `LMAC_PAGE_FUNC;
    wire logic on_led = i_reg_req.page == `LMAC_PAGE_LED;
    wire logic [7:0] a = i_reg_req.addr;
    logic [7:0] cfg_q;
    logic [7:0] gcl_q;
    logic [2:0] pullup_q;
    logic [2:0] pulldn_q;
    logic [7:0] test_gate_q;
    logic [7:0] scan_hold_q;
    logic [7:0] test_d2_q;
    logic [7:0] test_d3_q;
    logic [7:0] irq_mask_q;
    logic [7:0] onoff_q [24];
    wire logic gate_open = test_gate_q[0];
    wire logic wr_cfg = wr_ok & on_func & (a == `LMAC_OFS_CFG);
    wire logic wr_test = wr_ok & on_func & gate_open;
    wire logic trig = wr_cfg & i_reg_req.wdata[`LMAC_CFG_DET_BIT] & ~cfg_q[`LMAC_CFG_DET_BIT];
    wire lmac_pkg::lmac_sync_mode_t sync_mode = lmac_pkg::lmac_sync_mode_t'(cfg_q[`LMAC_CFG_SYNC_LSB +: 2]);
    wire logic ssd_on = cfg_q[`LMAC_CFG_SSD_BIT];
    wire logic irq_auto_clear_en = irq_mask_q[`LMAC_MASK_IAC_BIT];

    // no shutdown input touches these; contents survive both kinds
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cfg_q <= `LMAC_RST_BYTE;
            gcl_q <= `LMAC_RST_BYTE;
            pullup_q <= 3'h0;
            pulldn_q <= 3'h0;
            test_gate_q <= `LMAC_RST_BYTE;
            scan_hold_q <= `LMAC_RST_BYTE;
            test_d2_q <= `LMAC_RST_BYTE;
            test_d3_q <= `LMAC_RST_BYTE;
            irq_mask_q <= `LMAC_RST_BYTE;
        end
        else if (wr_ok && on_func)
        begin
            case (a)
                `LMAC_OFS_CFG: cfg_q <= i_reg_req.wdata;
                `LMAC_OFS_GCL: gcl_q <= i_reg_req.wdata;
                `LMAC_OFS_PULLUP: pullup_q <= i_reg_req.wdata[2:0];
                `LMAC_OFS_PULLDN: pulldn_q <= i_reg_req.wdata[2:0];
                `LMAC_OFS_TEST_GATE: test_gate_q <= {7'h00, i_reg_req.wdata[0]};
                `LMAC_OFS_SCAN_HOLD: if (wr_test) scan_hold_q <= {4'h0, i_reg_req.wdata[3:0]};
                `LMAC_OFS_TEST_D2: if (wr_test) test_d2_q <= {5'h00, i_reg_req.wdata[2:0]};
                `LMAC_OFS_TEST_D3: if (wr_test) test_d3_q <= i_reg_req.wdata;
                `LMAC_OFS_IRQ_MASK: irq_mask_q <= {2'h0, i_reg_req.wdata[5:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < 24; i++)
                onoff_q[i] <= `LMAC_RST_BYTE;
        end
        else if (wr_ok && on_led && a <= `LMAC_OFS_ONOFF_LAST)
            onoff_q[a[4:0]] <= i_reg_req.wdata;
    end

    // ==========================================================
    // row scan timing
    lmac_pkg::lmac_scan_state_t scan_q;
    logic [3:0] row_q;
    logic [15:0] cnt_q;
    wire logic hold = scan_hold_q[3:0] != 4'h0;
    wire logic slot_end = (scan_q == lmac_pkg::SCAN_SLOT) && (cnt_q == 16'(SLOT_CYC - 1)) && !hold;
    wire logic gap_end = (scan_q == lmac_pkg::SCAN_GAP) && (cnt_q == 16'(GAP_CYC - 1));
    wire logic scan_wrap = slot_end && (row_q == 4'(ROWS - 1));
    wire logic slave = sync_mode == lmac_pkg::SYNC_SLAVE;
    wire logic [3:0] row_next = (row_q == 4'(ROWS - 1)) ? 4'h0 : row_q + 4'h1;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            scan_q <= lmac_pkg::SCAN_SLOT;
            row_q <= 4'h0;
            cnt_q <= 16'h0000;
        end
        else if (hold)
            cnt_q <= 16'h0000;
        else if (slave && sync_rise)
        begin
            // the master's slot start retimes every row in lockstep
            scan_q <= lmac_pkg::SCAN_SLOT;
            row_q <= row_next;
            cnt_q <= 16'h0000;
        end
        else
        begin
            case (scan_q)
                lmac_pkg::SCAN_SLOT:
                begin
                    cnt_q <= slot_end ? 16'h0000 : cnt_q + 16'h0001;
                    if (slot_end)
                        scan_q <= lmac_pkg::SCAN_GAP;
                end
                lmac_pkg::SCAN_GAP:
                begin
                    // a slave parks at the gap end until the next rising edge of the sync input
                    if (gap_end && !slave)
                    begin
                        scan_q <= lmac_pkg::SCAN_SLOT;
                        row_q <= row_next;
                        cnt_q <= 16'h0000;
                    end
                    else if (!gap_end)
                        cnt_q <= cnt_q + 16'h0001;
                end
                default: scan_q <= lmac_pkg::SCAN_SLOT;
            endcase
        end
    end

    // ==========================================================
    // open/short capture
    lmac_pkg::lmac_det_state_t det_q;
    logic done_q;
    logic [15:0] open_q [ROWS];
    logic [15:0] short_q [ROWS];
    wire logic [15:0] row_on = {onoff_q[{row_q, 1'b1}], onoff_q[{row_q, 1'b0}]};
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            det_q <= lmac_pkg::DET_IDLE;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (det_q)
                lmac_pkg::DET_IDLE: if (trig) det_q <= lmac_pkg::DET_ALIGN;
                lmac_pkg::DET_ALIGN: if (scan_wrap) det_q <= lmac_pkg::DET_CAPTURE;
                lmac_pkg::DET_CAPTURE:
                    if (scan_wrap)
                    begin
                        det_q <= lmac_pkg::DET_IDLE;
                        done_q <= 1'b1;
                    end
                default: det_q <= lmac_pkg::DET_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int r = 0; r < ROWS; r++)
            begin
                open_q[r] <= 16'h0000;
                short_q[r] <= 16'h0000;
            end
        end
        else if (det_q == lmac_pkg::DET_CAPTURE && slot_end)
        begin
            open_q[row_q] <= (open_q[row_q] & ~row_on) | (col_open & row_on);
            short_q[row_q] <= (short_q[row_q] & ~row_on) | (col_short & row_on);
        end
    end

    logic any_open;
    logic any_short;
    always_comb
    begin
        any_open = 1'b0;
        any_short = 1'b0;
        for (int r = 0; r < ROWS; r++)
        begin
            any_open = any_open | (|open_q[r]);
            any_short = any_short | (|short_q[r]);
        end
    end

    // ==========================================================
    // interrupt
    logic irq_low_q;
    logic [4:0] irq_stat_q;
    logic [20:0] ac_cnt_q;
    wire logic [4:0] ev = {i_breath_done, done_q & any_short, done_q & any_open} & irq_mask_q[4:0];
    wire logic rd_stat = rd_ok & on_func & (a == `LMAC_OFS_IRQ_STAT);
    wire logic ac_fire = irq_auto_clear_en && (ac_cnt_q == 21'(AUTOCLR_CYC - 1));
    wire logic release_irq = irq_low_q & (rd_stat | ac_fire);
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            irq_low_q <= 1'b0;
            irq_stat_q <= 5'h00;
            ac_cnt_q <= 21'h000000;
        end
        else
        begin
            // a new event in the release cycle keeps the pin low
            if (|ev)
                irq_low_q <= 1'b1;
            else if (release_irq)
                irq_low_q <= 1'b0;
            irq_stat_q <= (release_irq ? 5'h00 : irq_stat_q) | ev;
            ac_cnt_q <= (irq_low_q && !release_irq) ? ac_cnt_q + 21'h000001 : 21'h000000;
        end
    end

    // ==========================================================
    // read data
    logic [7:0] rd_val;
    logic [7:0] bank_idx;
    always_comb
    begin
        rd_val = 8'h00;
        bank_idx = 8'h00;
        if (on_led && a <= `LMAC_OFS_ONOFF_LAST)
            rd_val = onoff_q[a[4:0]];
        else if (on_led && a >= `LMAC_OFS_OPEN_FIRST && a <= `LMAC_OFS_OPEN_LAST)
        begin
            bank_idx = a - `LMAC_OFS_OPEN_FIRST;
            rd_val = bank_idx[0] ? open_q[bank_idx[4:1]][15:8] : open_q[bank_idx[4:1]][7:0];
        end
        else if (on_led && a >= `LMAC_OFS_SHORT_FIRST && a <= `LMAC_OFS_SHORT_LAST)
        begin
            bank_idx = a - `LMAC_OFS_SHORT_FIRST;
            rd_val = bank_idx[0] ? short_q[bank_idx[4:1]][15:8] : short_q[bank_idx[4:1]][7:0];
        end
        else if (on_func)
        begin
            case (a)
                `LMAC_OFS_CFG: rd_val = cfg_q;
                `LMAC_OFS_GCL: rd_val = gcl_q;
                `LMAC_OFS_PULLUP: rd_val = {5'h00, pullup_q};
                `LMAC_OFS_PULLDN: rd_val = {5'h00, pulldn_q};
                `LMAC_OFS_TEST_GATE: rd_val = test_gate_q;
                `LMAC_OFS_SCAN_HOLD: rd_val = gate_open ? scan_hold_q : 8'h00;
                `LMAC_OFS_TEST_D2: rd_val = gate_open ? test_d2_q : 8'h00;
                `LMAC_OFS_TEST_D3: rd_val = gate_open ? test_d3_q : 8'h00;
                `LMAC_OFS_IRQ_MASK: rd_val = irq_mask_q;
                `LMAC_OFS_IRQ_STAT: rd_val = {3'h0, irq_stat_q};
                default: rd_val = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // matrix drive and registered outputs
    logic [11:0] sink_d;
    logic [15:0] src_d;
    logic [3:0] drive_row;
    // pulls only in the blanking gap; a held row leaves the others floating
    wire logic gap_now = (scan_q == lmac_pkg::SCAN_GAP) && !hold;
    always_comb
    begin
        sink_d = 12'h000;
        drive_row = hold ? scan_hold_q[3:0] - 4'h1 : row_q;
        if (hold && scan_hold_q[3:0] <= 4'(ROWS))
            sink_d = 12'(12'h001 << drive_row);
        else if (!hold && scan_q == lmac_pkg::SCAN_SLOT)
            sink_d = 12'(12'h001 << row_q);
        if (!hw_on)
            sink_d = 12'h000;
        src_d = (|sink_d && ssd_on) ? {onoff_q[{drive_row, 1'b1}], onoff_q[{drive_row, 1'b0}]} : 16'h0000;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reg_rdata <= 8'h00;
            o_sync_out <= 1'b0;
            o_sync_oe <= 1'b0;
            o_irq_n_pin_out <= 1'b0;
            o_irq_n_pin_oe <= 1'b0;
            o_row_sink_line <= 12'h000;
            o_column_source_line <= 16'h0000;
            o_row_pullup_en <= 12'h000;
            o_column_pulldown_en <= 16'h0000;
            o_row_pullup_sel <= 3'h0;
            o_column_pulldown_sel <= 3'h0;
            o_global_current_level <= 8'h00;
            o_analog_en <= 1'b0;
            o_breath_en <= 1'b0;
            o_detect_busy <= 1'b0;
        end
        else
        begin
            if (rd_ok)
                o_reg_rdata <= rd_val;
            o_sync_out <= scan_q == lmac_pkg::SCAN_SLOT;
            o_sync_oe <= sync_mode == lmac_pkg::SYNC_MASTER;
            o_irq_n_pin_out <= 1'b0;
            o_irq_n_pin_oe <= irq_low_q;
            o_row_sink_line <= sink_d;
            o_column_source_line <= src_d;
            o_row_pullup_en <= (pullup_q != 3'h0 && hw_on && gap_now) ? ~sink_d : 12'h000;
            o_column_pulldown_en <= (pulldn_q != 3'h0 && hw_on && gap_now) ? ~src_d : 16'h0000;
            o_row_pullup_sel <= pullup_q;
            o_column_pulldown_sel <= pulldn_q;
            o_global_current_level <= gcl_q;
            o_analog_en <= hw_on;
            o_breath_en <= cfg_q[`LMAC_CFG_BREATH_BIT];
            o_detect_busy <= det_q != lmac_pkg::DET_IDLE;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    a_trig_start: assert property (trig |=> det_q == lmac_pkg::DET_ALIGN)
        else $error("trigger edge did not start capture");
    a_rewrite_none: assert property (wr_cfg && cfg_q[`LMAC_CFG_DET_BIT] |-> !trig)
        else $error("rewriting set trigger started capture");
    a_irq_drop: assert property (|ev |=> ##1 o_irq_n_pin_oe)
        else $error("event did not pull interrupt low");
    a_stat_set: assert property (ev[0] |=> irq_stat_q[0] && irq_low_q)
        else $error("open status not set with interrupt");
    a_rd_release: assert property (rd_stat && irq_low_q && ev == 5'h00 |=> !irq_low_q ##1 !o_irq_n_pin_oe)
        else $error("status read did not release interrupt");
    a_auto_clear: assert property (irq_low_q && irq_auto_clear_en && ac_cnt_q == 21'(AUTOCLR_CYC - 1) && ev == 5'h00 |=> !irq_low_q)
        else $error("auto clear did not release interrupt");
    a_stat_zero: assert property (!irq_low_q |-> irq_stat_q == 5'h00)
        else $error("status left set with interrupt high");
    a_sync_float: assert property (sync_mode != lmac_pkg::SYNC_MASTER |=> !o_sync_oe)
        else $error("sync pin driven outside master mode");
    a_gate_block: assert property (wr_ok && on_func && a == `LMAC_OFS_SCAN_HOLD && !gate_open |=> $stable(scan_hold_q))
        else $error("scan hold written while gate closed");
    a_hold_freeze: assert property (hold && $past(hold) |-> $stable(row_q) && cnt_q == 16'h0000)
        else $error("row scan moved during hold");
    a_pull_off: assert property ((o_row_pullup_en & o_row_sink_line) == 12'h000)
        else $error("pull-up enabled on a sinking row");
    a_ssd_blank: assert property (!ssd_on |=> o_column_source_line == 16'h0000)
        else $error("sources on in soft shutdown");
    a_bus_reset: assert property (bus_rst && i_reg_req.wr |=> $stable(cfg_q) && $stable(irq_mask_q))
        else $error("write accepted while bus reset held");

    c_capture: cover property (det_q == lmac_pkg::DET_CAPTURE ##1 done_q);
    c_rd_release: cover property (irq_low_q && rd_stat);
    c_auto_clear: cover property (irq_low_q && ac_fire);
    c_hold_row: cover property (hold && o_row_sink_line != 12'h000);
endmodule : lmac_top

// ### verif/lmac_host_model.sv
/*
 * Host controller model: register writes, reads and host-side sequences.
 * Assumes the device takes one-cycle strobes on the rising clock edge.
 */
`timescale 1ns/1ps
module lmac_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output lmac_pkg::lmac_reg_req_t o_req
);
    initial o_req = '0;
    // ==========================================
    // bus cycles
    task automatic wr(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge i_clk);
        o_req <= '{1'b1, 1'b0, pg, a, d};
        @(posedge i_clk);
        o_req <= '0;
    end
    endtask : wr
    task automatic rd(input logic [1:0] pg, input logic [7:0] a, output logic [7:0] d);
    begin
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b1, pg, a, 8'h00};
        @(posedge i_clk);
        o_req <= '0;
        @(posedge i_clk);
        #1 d = i_rdata;
    end
    endtask : rd
    // ==========================================
    // host sequences
    task automatic trigger(input logic [7:0] cfg);
    begin
        wr(2'h3, 8'h01, 8'h01);
        wr(2'h3, 8'h00, cfg & 8'hfb);
        wr(2'h3, 8'h00, cfg | 8'h04);
    end
    endtask : trigger
    task automatic recover();
    begin
        wr(2'h3, 8'he0, 8'h01);
        wr(2'h3, 8'he1, 8'h00);
        wr(2'h3, 8'he2, 8'h00);
        wr(2'h3, 8'he3, 8'h00);
        wr(2'h3, 8'he0, 8'h01);
    end
    endtask : recover
endmodule : lmac_host_model

// ### verif/led_matrix_aux_control_bench.sv
/*
 * Self-checking bench of the auxiliary control block.
 * Assumes lmac_host_model drives the register strobes.
 */
`timescale 1ns/1ps
module led_matrix_aux_control_bench;
    logic clk = 0, rstn = 0, bus_rst = 0, hw_n = 1, sync_in = 0, slave_run = 0;
    logic [15:0] col_open = 16'h0001, col_short = 16'h0000;
    logic [2:0] bd = 3'h0;
    logic [7:0] rdata, v, gcl;
    logic [11:0] sink, pu_en, sv;
    logic [15:0] src, pd_en;
    logic oe, sync_oe, busy, an_en, sync_out, irq_out, br_en;
    logic [2:0] pu_sel, pd_sel;
    lmac_pkg::lmac_reg_req_t req;
    int mismatches = 0, check_count = 0;
    always #2 clk = ~clk;
    // link clock only runs while the slave test wants it
    always #24 sync_in = slave_run ? ~sync_in : 1'b0;
    lmac_host_model lmac_host_model_inst (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    lmac_top #(.SLOT_CYC(20), .GAP_CYC(4), .AUTOCLR_CYC(50)) lmac_top_inst (
        .i_ref_clk(clk), .i_rstn(rstn), .i_reg_req(req), .o_reg_rdata(rdata),
        .i_bus_iface_reset_pin(bus_rst), .i_hw_shutdown_n_pin(hw_n), .i_sync_in(sync_in),
        .o_sync_out(sync_out), .o_sync_oe(sync_oe), .o_irq_n_pin_out(irq_out), .o_irq_n_pin_oe(oe),
        .i_col_open(col_open), .i_col_short(col_short), .i_breath_done(bd),
        .o_row_sink_line(sink), .o_column_source_line(src), .o_row_pullup_en(pu_en),
        .o_column_pulldown_en(pd_en), .o_row_pullup_sel(pu_sel), .o_column_pulldown_sel(pd_sel),
        .o_global_current_level(gcl), .o_analog_en(an_en), .o_breath_en(br_en), .o_detect_busy(busy));
    // ==========================================
    // checking and closing
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic pulse(input logic [2:0] p);
        @(posedge clk) bd <= p;
        @(posedge clk) bd <= 3'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask : pulse
    always @(negedge clk)
        if (rstn && |{pu_en & sink, pd_en & src})
            chk(16'h1, 16'h0);
    initial
    begin
        #100000;
        mismatches++;
        complete_run();
    end
    // ==========================================
    // tests
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        #1 chk(src, 16'h0);
        chk(sync_oe, 1'b0);
        lmac_host_model_inst.rd(2'h3, 8'he0, v); chk(v, 8'h00);
        lmac_host_model_inst.wr(2'h3, 8'he1, 8'h05);
        lmac_host_model_inst.rd(2'h3, 8'he1, v); chk(v, 8'h00);
        lmac_host_model_inst.wr(2'h3, 8'he0, 8'h01);
        lmac_host_model_inst.wr(2'h3, 8'he1, 8'h05);
        lmac_host_model_inst.rd(2'h3, 8'he1, v); chk(v, 8'h05);
        repeat (3) @(posedge clk);
        #1 chk(sink, 12'h010);
        lmac_host_model_inst.recover();
        $display("test gate done");
        lmac_host_model_inst.wr(2'h3, 8'h0f, 8'h07);
        lmac_host_model_inst.wr(2'h3, 8'h10, 8'h07);
        lmac_host_model_inst.trigger(8'h01);
        repeat (3) @(posedge clk);
        #1 chk(busy, 1'b1);
        chk({pu_sel, pd_sel}, 6'h3f);
        chk(gcl, 8'h01);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
        lmac_host_model_inst.rd(2'h0, 8'h18, v); chk(v, 8'h00);
        lmac_host_model_inst.wr(2'h0, 8'h00, 8'hff);
        lmac_host_model_inst.trigger(8'h01);
        repeat (3) @(posedge clk);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
        lmac_host_model_inst.rd(2'h0, 8'h18, v); chk(v, 8'h01);
        $display("detect done");
        lmac_host_model_inst.wr(2'h3, 8'hf0, 8'h04);
        pulse(3'h2); chk(oe, 1'b0);
        pulse(3'h1); chk(oe, 1'b1);
        chk(irq_out, 1'b0);
        lmac_host_model_inst.rd(2'h3, 8'hf1, v); chk(v, 8'h04);
        @(posedge clk);
        #1 chk(oe, 1'b0);
        lmac_host_model_inst.rd(2'h3, 8'hf1, v); chk(v, 8'h00);
        lmac_host_model_inst.wr(2'h3, 8'hf0, 8'h24);
        pulse(3'h1); chk(oe, 1'b1);
        repeat (55) @(posedge clk);
        #1 chk(oe, 1'b0);
        lmac_host_model_inst.rd(2'h3, 8'hf1, v); chk(v, 8'h00);
        $display("interrupt done");
        lmac_host_model_inst.wr(2'h3, 8'h00, 8'h43);
        repeat (2) @(posedge clk);
        #1 chk(sync_oe, 1'b1);
        chk(br_en, 1'b1);
        @(negedge sync_out);
        #1 chk(sink, 12'h000);
        chk(pu_en, 12'hfff);
        chk(pd_en, 16'hffff);
        @(posedge sync_out);
        #1 chk(|sink, 1'b1);
        chk(pu_en, 12'h000);
        slave_run = 1;
        lmac_host_model_inst.wr(2'h3, 8'h00, 8'h81);
        repeat (40) @(posedge clk);
        #1 chk(sync_oe, 1'b0);
        @(posedge sync_in);
        repeat (5) @(posedge clk);
        #1 sv = sink;
        @(posedge sync_in);
        repeat (5) @(posedge clk);
        #1 chk(sink, {sv[10:0], sv[11]});
        slave_run = 0;
        lmac_host_model_inst.wr(2'h3, 8'h00, 8'hc1);
        repeat (2) @(posedge clk);
        #1 chk(sync_oe, 1'b0);
        $display("sync done");
        @(posedge clk) bus_rst <= 1;
        repeat (4) @(posedge clk);
        lmac_host_model_inst.wr(2'h3, 8'hf0, 8'h1f);
        @(posedge clk) bus_rst <= 0;
        repeat (4) @(posedge clk);
        lmac_host_model_inst.rd(2'h3, 8'hf0, v); chk(v, 8'h24);
        @(posedge clk) hw_n <= 0;
        repeat (4) @(posedge clk);
        #1 chk(an_en, 1'b0);
        lmac_host_model_inst.wr(2'h3, 8'h01, 8'h5a);
        lmac_host_model_inst.rd(2'h3, 8'h01, v); chk(v, 8'h5a);
        lmac_host_model_inst.rd(2'h3, 8'h00, v); chk(v, 8'hc1);
        @(posedge clk) hw_n <= 1;
        $display("shutdown done");
        complete_run();
    end
endmodule : led_matrix_aux_control_bench
